// ---- design/plc_pkg.sv ----
// shared constants, register map and carrier types for the pll clock manager
package plc_pkg;
    localparam int CLK_MHZ = 50;
    localparam int LOCK_TIME_US = 10;
    // longest lock time in cycles, an exact product: 10 us at 50 MHz
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
    localparam int NUM_PLL = 4;
    localparam int SERIAL_PLLS = 2;
    localparam int SERIAL_FACTOR = 8;
    localparam int MK_MIN = 2;
    localparam int MK_MAX = 160;
    localparam int NV_MIN = 1;
    localparam int NV_MAX = 16;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ERR = 8'h04;
    localparam logic [7:0] ADDR_PLL = 8'h10;
    localparam int PLL_STRIDE = 16;
    localparam logic [3:0] OFS_CFG0 = 4'h0;
    localparam logic [3:0] OFS_CFG1 = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;

    localparam int CTRL_F1 = 0;
    localparam int CTRL_F2 = 2;
    localparam int CTRL_SHARE = 4;
    localparam int M_LSB = 0;
    localparam int K_LSB = 8;
    localparam int N_LSB = 16;
    localparam int V_LSB = 24;
    localparam int ERR_PAIR = 0;
    localparam int ERR_RANGE = 1;
    localparam int ERR_PIN1 = 2;
    localparam int ERR_LATE = 3;

    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [3:0] ERR_RST = 4'h0;
    localparam logic [31:0] CFG0_RST = 32'h0101_0202;
    localparam logic [31:0] CFG1_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        FAC_X1 = 2'b00,
        FAC_X2 = 2'b01,
        FAC_X4 = 2'b10
    } plc_factor_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEASURE = 2'b01,
        ST_ALIGN = 2'b10,
        ST_LOCKED = 2'b11
    } plc_lock_st_t;

    // cfg1 upper bits down to cfg0, as seen by software
    typedef struct packed {
        logic [7:0] spare1;
        logic src_pin2;
        logic uio_oe;
        logic uio_out;
        logic serial;
        logic lock_pin_en;
        logic pin_out;
        logic fb_ext;
        logic use_v;
        logic [1:0] spare0;
        logic signed [11:0] delay;
        logic [1:0] phase;
        logic [2:0] pad_v;
        logic [4:0] v;
        logic [2:0] pad_n;
        logic [4:0] n;
        logic [7:0] k;
        logic [7:0] m;
    } plc_cfg_t;

    typedef struct packed {
        logic [7:0] mul;
        logic [11:0] div;
        logic [1:0] phase;
        logic signed [11:0] delay;
        logic fb_ext;
    } plc_core_t;
endpackage

// ---- design/plc_pll_clock_mgr.sv ----
// pll clock manager top: registers, factor checks, pin muxing and pll cores
// Operation
// R1 - The second clock pin may feed the synchronizing and the multiplying pll together.
// R2 - While the second pin feeds both plls the first clock pin is left unused.
// R3 - Clock 1 factor may not exceed clock 2 factor, both taken from x1, x2 and x4.
// R4 - The multiplier output runs at m/(n*k) or m/(n*v), m and k 2..160, n and v 1..16.
// R5 - The output phase moves in quarter-period steps of 90 degrees.
// R6 - The output delay moves by a signed amount of at most one clock period.
// R7 - Up to four independent plls exist, two of them also serial capable.
// R8 - A pll output can be driven onto a device pin for outside devices.
// R9 - The feedback can run off chip so alignment is made at the external pin.
// R10 - Serial capable plls multiply the forwarded clock by eight for bit capture.
// R11 - Each pll drives its own lock indicator high once locked.
// R12 - An unused lock indicator pin acts as an ordinary user pin.
// R13 - The base variant locks during configuration and is ready when it ends.
// R14 - The enhanced variant ignores its input until configuration ends.
// R15 - The board clock must meet the input limits or lock may fail.
// R16 - Lock is reached within 10 us of a good input clock.
// R17 - Lock drops on loss, and the clock tree is held in reset until relock.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module plc_pll_clock_mgr #(
    parameter bit ENHANCED = 1'b1,
    parameter int NUM_PLL = plc_pkg::NUM_PLL,
    parameter int SERIAL_PLLS = plc_pkg::SERIAL_PLLS,
    parameter int PER_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic first_dedicated_clock_pin,
    input wire logic second_dedicated_clock_pin,
    input wire logic cfg_done,
    input wire logic [NUM_PLL-1:0] ext_fb,
    output logic [NUM_PLL-1:0] tree_en,
    output logic [NUM_PLL-1:0] tree_hold,
    output logic [NUM_PLL-1:0] out_clk_o,
    output logic [NUM_PLL-1:0] out_clk_oe_n,
    input wire logic [NUM_PLL-1:0] lock_pin_i,
    output logic [NUM_PLL-1:0] lock_pin_o,
    output logic [NUM_PLL-1:0] lock_pin_oe_n
);
    localparam int IW = NUM_PLL > 1 ? $clog2(NUM_PLL) : 1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    function automatic logic pll_hit(input logic [7:0] a);
        logic [8:0] top;
        top = 9'(int'(plc_pkg::ADDR_PLL) + NUM_PLL * plc_pkg::PLL_STRIDE);
        return a >= plc_pkg::ADDR_PLL && {1'b0, a} < top &&
            a[3:0] <= plc_pkg::OFS_STAT && a[1:0] == 2'b00;
    endfunction

    function automatic logic [IW-1:0] pll_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - plc_pkg::ADDR_PLL;
        return d[IW+3:4];
    endfunction

    function automatic logic in_range(input logic [7:0] x, input int lo, input int hi);
        return int'(x) >= lo && int'(x) <= hi;
    endfunction

    function automatic logic factor_ok(input logic [1:0] f1, input logic [1:0] f2);
        return f2 <= plc_pkg::FAC_X4 && f1 <= f2;
    endfunction

    function automatic logic [7:0] fac_mul(input logic [1:0] f);
        return 8'h01 << f;
    endfunction

    logic [4:0] ctrl;
    logic [3:0] err;
    logic [31:0] cfg0 [NUM_PLL];
    logic [31:0] cfg1 [NUM_PLL];
    logic pin1_q;

    logic [NUM_PLL-1:0] pulse_c;
    logic [NUM_PLL-1:0] locked_c;
    logic [NUM_PLL-1:0] late_c;
    logic [NUM_PLL-1:0] next_tree_en;
    logic [NUM_PLL-1:0] next_out_clk;
    logic [NUM_PLL-1:0] next_out_oe_n;
    logic [NUM_PLL-1:0] next_lock_o;
    logic [NUM_PLL-1:0] next_lock_oe_n;
    logic [31:0] stat_w [NUM_PLL];

    // address decode
    wire hit = pll_hit(addr);
    wire [IW-1:0] idx = pll_idx(addr);
    wire [3:0] ofs = addr[3:0];
    wire wr_ctrl = wr && addr == plc_pkg::ADDR_CTRL;
    wire wr_err = wr && addr == plc_pkg::ADDR_ERR;
    wire wr_cfg0 = wr && hit && ofs == plc_pkg::OFS_CFG0;
    wire wr_cfg1 = wr && hit && ofs == plc_pkg::OFS_CFG1;

    // write screening
    wire pair_ok = factor_ok(wdata[plc_pkg::CTRL_F1 +: 2], wdata[plc_pkg::CTRL_F2 +: 2]); // R3
    wire m_ok = in_range(wdata[plc_pkg::M_LSB +: 8], plc_pkg::MK_MIN, plc_pkg::MK_MAX);
    wire k_ok = in_range(wdata[plc_pkg::K_LSB +: 8], plc_pkg::MK_MIN, plc_pkg::MK_MAX);
    wire n_ok = in_range({3'b000, wdata[plc_pkg::N_LSB +: 5]}, plc_pkg::NV_MIN, plc_pkg::NV_MAX);
    wire v_ok = in_range({3'b000, wdata[plc_pkg::V_LSB +: 5]}, plc_pkg::NV_MIN, plc_pkg::NV_MAX);
    wire range_ok = m_ok && k_ok && n_ok && v_ok; // R4
    wire share = !ENHANCED && ctrl[plc_pkg::CTRL_SHARE];
    wire pin1_rise = first_dedicated_clock_pin && !pin1_q;

    // flags that hardware sets; a set in the clear cycle survives
    wire [3:0] err_set = {
        |late_c,
        share && pin1_rise,
        wr_cfg0 && !range_ok,
        wr_ctrl && !pair_ok
    };
    wire [3:0] err_clr = wr_err ? wdata[3:0] : 4'h0;
    wire [3:0] next_err = (err & ~err_clr) | err_set; // R2

    // read mux
    wire [31:0] pll_word = ofs == plc_pkg::OFS_CFG0 ? cfg0[idx] :
        (ofs == plc_pkg::OFS_CFG1 ? cfg1[idx] : stat_w[idx]);
    wire [31:0] rd_word = addr == plc_pkg::ADDR_CTRL ? {27'h0, ctrl} :
        (addr == plc_pkg::ADDR_ERR ? {28'h0, err} : (hit ? pll_word : 32'h0000_0000));

    for (genvar i = 0; i < NUM_PLL; i++) begin : g_pll
        localparam bit SER_OK = i < SERIAL_PLLS;
        localparam bit BASE_USED = i < 2;
        plc_pkg::plc_cfg_t c;
        plc_pkg::plc_core_t ctl;
        logic [PER_W-1:0] period;

        assign c = plc_pkg::plc_cfg_t'({cfg1[i], cfg0[i]});

        // base variant: pll 0 takes the clock 1 factor, pll 1 the clock 2 factor
        wire [1:0] base_fac = i == 0 ? ctrl[plc_pkg::CTRL_F1 +: 2] : ctrl[plc_pkg::CTRL_F2 +: 2];
        wire [11:0] post = c.use_v ? {7'b0000000, c.v} : {4'b0000, c.k};
        wire [11:0] enh_div = {7'b0000000, c.n} * post; // R4
        wire serial = SER_OK && c.serial; // R7
        wire [7:0] mul_w = serial ? 8'(plc_pkg::SERIAL_FACTOR) :
            (ENHANCED ? c.m : fac_mul(base_fac)); // R10
        wire [11:0] div_w = (serial || !ENHANCED) ? 12'h001 : enh_div;

        assign ctl = '{
            mul: mul_w,
            div: div_w,
            phase: ENHANCED ? c.phase : 2'b00,
            delay: ENHANCED ? c.delay : 12'sh000,
            fb_ext: ENHANCED && c.fb_ext
        };

        // one board trace can serve both base plls
        wire src2 = ENHANCED ? c.src_pin2 : (i != 0 || share); // R1
        wire ref_c = src2 ? second_dedicated_clock_pin : first_dedicated_clock_pin;
        // programmable input standard only takes effect after configuration
        wire en_c = ENHANCED ? cfg_done : BASE_USED; // R14 R13

        plc_pll_core #(
            .PER_W(PER_W),
            .LOCK_CYC(plc_pkg::LOCK_CYCLES)
        ) u_core (
            .clk(clk),
            .rst(rst),
            .en(en_c),
            .ref_lvl(ref_c),
            .fb_lvl(ext_fb[i]),
            .ctl(ctl),
            .out_pulse(pulse_c[i]),
            .locked(locked_c[i]),
            .late(late_c[i]),
            .period(period)
        );

        assign stat_w[i] = 32'({period, 13'h0, late_c[i], lock_pin_i[i], locked_c[i]});
        // clock tree sees edges only once configuration is over
        assign next_tree_en[i] = pulse_c[i] && cfg_done; // R13
        assign next_out_clk[i] = c.pin_out && (out_clk_o[i] ^ pulse_c[i]); // R8
        assign next_out_oe_n[i] = !c.pin_out;
        assign next_lock_o[i] = c.lock_pin_en ? locked_c[i] : c.uio_out; // R11
        assign next_lock_oe_n[i] = c.lock_pin_en ? 1'b0 : !c.uio_oe; // R12

        sequence s_unlock;
            locked_c[i] ##1 !locked_c[i];
        endsequence

        a_out_pin_toggle: // R8
        assert property (c.pin_out && pulse_c[i] |=> out_clk_o[i] != $past(out_clk_o[i]))
            else $error("pin clock missed a toggle");

        a_lock_pin_drive: // R11
        assert property (c.lock_pin_en && locked_c[i] |=> lock_pin_o[i] && !lock_pin_oe_n[i])
            else $error("lock pin not driven high");

        a_user_pin_mode: // R12
        assert property (!c.lock_pin_en |=> lock_pin_oe_n[i] == !$past(c.uio_oe)
            && lock_pin_o[i] == $past(c.uio_out))
            else $error("user pin mode wrong");

        a_cfg_input_gate: // R14
        assert property (!cfg_done [*2] |-> !ENHANCED || !locked_c[i])
            else $error("locked before configuration end");

        a_tree_hold_loss: // R17
        assert property (s_unlock |=> tree_hold[i] ##1 (tree_hold[i] || $past(locked_c[i])))
            else $error("tree not held after lock loss");

        a_serial_factor: // R10
        assert property (SER_OK && c.serial |-> ctl.mul == 8'(plc_pkg::SERIAL_FACTOR)
            && ctl.div == 12'h001)
            else $error("serial pll not at times eight");

        a_share_source: // R1
        assert property (!ENHANCED && share |-> ref_c == second_dedicated_clock_pin)
            else $error("shared pll not fed from second pin");
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= plc_pkg::CTRL_RST;
            err <= plc_pkg::ERR_RST;
            pin1_q <= 1'b0;
        end else begin
            if (wr_ctrl && pair_ok) begin
                ctrl <= wdata[4:0]; // R3
            end
            err <= next_err;
            pin1_q <= first_dedicated_clock_pin;
        end
    end

    // rejected factor words leave the old setting in place
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int j = 0; j < NUM_PLL; j++) begin
                cfg0[j] <= plc_pkg::CFG0_RST;
                cfg1[j] <= plc_pkg::CFG1_RST;
            end
        end else begin
            if (wr_cfg0 && range_ok) begin
                cfg0[idx] <= wdata; // R4
            end
            if (wr_cfg1) begin
                cfg1[idx] <= wdata; // R5
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tree_en <= '0;
            tree_hold <= '1;
            out_clk_o <= '0;
            out_clk_oe_n <= '1;
            lock_pin_o <= '0;
            lock_pin_oe_n <= '1;
        end else begin
            tree_en <= next_tree_en;
            tree_hold <= ~locked_c; // R17
            out_clk_o <= next_out_clk;
            out_clk_oe_n <= next_out_oe_n;
            lock_pin_o <= next_lock_o;
            lock_pin_oe_n <= next_lock_oe_n;
        end
    end

    a_pair_reject: // R3
    assert property (wr_ctrl && !pair_ok |=> ctrl == $past(ctrl) && err[plc_pkg::ERR_PAIR])
        else $error("illegal factor pair accepted");

    a_range_reject: // R4
    assert property (wr_cfg0 && !range_ok && !wr_err |=> err[plc_pkg::ERR_RANGE]
        ##1 (err[plc_pkg::ERR_RANGE] || $past(wr_err)))
        else $error("out of range factor not flagged");
endmodule

`default_nettype wire

// ---- design/plc_pll_core.sv ----
// one pll: reference period tracking, lock state and fractional output enables
`timescale 1ns/1ps
`default_nettype none

module plc_pll_core #(
    parameter int PER_W = 16,
    parameter int LOCK_CYC = plc_pkg::LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic ref_lvl,
    input wire logic fb_lvl,
    input wire plc_pkg::plc_core_t ctl,
    output logic out_pulse,
    output logic locked,
    output logic late,
    output logic [PER_W-1:0] period
);
    localparam int THR_W = PER_W + 12;
    localparam int WT_W = $clog2(LOCK_CYC + 1);

    plc_pkg::plc_lock_st_t state, next_state;
    logic ref_q;
    logic fb_q;
    logic [PER_W-1:0] cnt;
    logic [1:0] stable;
    logic [THR_W-1:0] acc;
    logic [WT_W-1:0] wait_cnt;

    wire ref_rise = ref_lvl & ~ref_q;
    wire fb_rise = fb_lvl & ~fb_q;
    wire [PER_W-1:0] next_period = cnt + 1'b1;
    // one cycle of slack: the reference is only sampled at clk
    wire match = (next_period + 1'b1 >= period) && (next_period <= period + 1'b1);
    wire lost = {1'b0, cnt} > {period, 1'b0};
    wire [THR_W-1:0] thr = period * ctl.div;
    wire [THR_W:0] sum = acc + ctl.mul;
    wire wrap = sum >= {1'b0, thr};
    wire signed [THR_W+1:0] thr_s = signed'({2'b00, thr});
    wire signed [THR_W+1:0] dly_raw = ctl.delay * signed'({1'b0, ctl.mul});
    // shift limited to one output period either way
    wire signed [THR_W+1:0] dly = dly_raw > thr_s ? thr_s :
        (dly_raw < -thr_s ? -thr_s : dly_raw); // R6
    wire [THR_W-1:0] qtr_u = ctl.phase * thr[THR_W-1:2]; // R5
    wire signed [THR_W+1:0] pre0 = signed'({2'b00, qtr_u}) + dly + thr_s;
    wire signed [THR_W+1:0] pre1 = pre0 >= thr_s ? pre0 - thr_s : pre0;
    wire signed [THR_W+1:0] pre2 = pre1 >= thr_s ? pre1 - thr_s : pre1;
    wire enter_lock = next_state == plc_pkg::ST_LOCKED && state != plc_pkg::ST_LOCKED;
    // output keeps running while aligning, or an off-chip loop could never close
    wire run_out = state == plc_pkg::ST_LOCKED || state == plc_pkg::ST_ALIGN; // R9

    always_comb begin
        next_state = state;
        case (state)
            plc_pkg::ST_IDLE: begin
                next_state = plc_pkg::ST_MEASURE;
            end
            plc_pkg::ST_MEASURE: begin
                if (ref_rise && match && stable == 2'd2) begin
                    next_state = ctl.fb_ext ? plc_pkg::ST_ALIGN : plc_pkg::ST_LOCKED; // R9
                end
            end
            plc_pkg::ST_ALIGN: begin
                if (lost) begin
                    next_state = plc_pkg::ST_MEASURE;
                end else if (fb_rise) begin
                    next_state = plc_pkg::ST_LOCKED; // R9
                end
            end
            plc_pkg::ST_LOCKED: begin
                if (lost || (ref_rise && !match)) begin
                    next_state = plc_pkg::ST_MEASURE; // R17
                end
            end
            default: begin
                next_state = plc_pkg::ST_IDLE;
            end
        endcase
        if (!en) begin
            next_state = plc_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= plc_pkg::ST_IDLE;
            ref_q <= 1'b0;
            fb_q <= 1'b0;
            cnt <= '0;
            period <= '0;
            stable <= 2'd0;
        end else begin
            state <= next_state;
            ref_q <= ref_lvl;
            fb_q <= fb_lvl;
            cnt <= ref_rise ? '0 : (&cnt ? cnt : cnt + 1'b1);
            // nothing is learnt from the input while disabled
            if (!en) begin
                period <= '0;
                stable <= 2'd0;
            end else if (ref_rise) begin // R14
                period <= next_period;
                stable <= match ? (stable == 2'd2 ? stable : stable + 2'd1) : 2'd0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc <= '0;
            out_pulse <= 1'b0;
        end else if (enter_lock) begin
            acc <= pre2[THR_W-1:0];
            out_pulse <= 1'b0;
        end else begin
            acc <= wrap ? THR_W'(sum - {1'b0, thr}) : sum[THR_W-1:0];
            out_pulse <= run_out && wrap; // R4
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= '0;
        end else if (!en || state == plc_pkg::ST_LOCKED) begin
            wait_cnt <= '0;
        end else if (wait_cnt != WT_W'(LOCK_CYC)) begin
            wait_cnt <= wait_cnt + 1'b1;
        end
    end

    assign late = wait_cnt == WT_W'(LOCK_CYC); // R16
    assign locked = state == plc_pkg::ST_LOCKED; // R11
endmodule

`default_nettype wire

// ---- tb/plc_board_clk.sv ----
// board clock source and off-chip feedback trace model
`timescale 1ns/1ps
`default_nettype none

module plc_board_clk (
    input wire logic clk,
    input wire logic run1,
    input wire logic run2,
    input wire logic [7:0] half,
    input wire logic [3:0] out_clk,
    output logic pin1,
    output logic pin2,
    output logic [3:0] fb
);
    int cnt = 0;
    logic lvl = 1'b0;
    logic [3:0] dly = 4'h0;
    // one steady period, a compliant source never drifts
    always @(posedge clk) begin
        cnt <= (cnt + 1 >= int'(half)) ? 0 : cnt + 1;
        if (cnt + 1 >= int'(half)) begin
            lvl <= ~lvl;
        end
        dly <= out_clk;
        fb <= dly;
    end
    // a stopped source stands low, so an unused pin stays quiet
    assign pin1 = run1 & lvl;
    assign pin2 = run2 & lvl;
endmodule
`default_nettype wire

// ---- tb/plc_pll_clock_mgr_tb.sv ----
// self-checking bench for the pll clock manager
`timescale 1ns/1ps
`default_nettype none

module plc_pll_clock_mgr_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cfg_done = 1'b0;
    logic run1 = 1'b1;
    logic run2 = 1'b1;
    logic [7:0] half = 8'h08;
    logic [3:0] user_lvl = 4'hf;
    wire logic [31:0] rdata, rdata_base;
    wire logic pin1;
    wire logic pin2;
    wire logic [3:0] ext_fb, tree_en, tree_hold, out_clk_o, out_clk_oe_n;
    wire logic [3:0] lock_pin_i, lock_pin_o, lock_pin_oe_n, hold_base;
    int num_errors = 0;
    int compares = 0;
    int pcnt [4];
    int togs;

    always #10 clk = ~clk;
    // wire level: block drives when oe_n low, else the board value
    assign lock_pin_i = (lock_pin_o & ~lock_pin_oe_n) | (user_lvl & lock_pin_oe_n);

    plc_pll_clock_mgr u_plc_pll_clock_mgr (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .first_dedicated_clock_pin(pin1), .second_dedicated_clock_pin(pin2),
        .cfg_done(cfg_done), .ext_fb(ext_fb), .tree_en(tree_en), .tree_hold(tree_hold),
        .out_clk_o(out_clk_o), .out_clk_oe_n(out_clk_oe_n), .lock_pin_i(lock_pin_i),
        .lock_pin_o(lock_pin_o), .lock_pin_oe_n(lock_pin_oe_n));
    // base variant shares bus and board clock, only its lock and read data are watched
    plc_pll_clock_mgr #(.ENHANCED(1'b0)) u_plc_pll_clock_mgr_base (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_base),
        .first_dedicated_clock_pin(pin1), .second_dedicated_clock_pin(pin2),
        .cfg_done(cfg_done), .ext_fb(ext_fb), .tree_en(), .tree_hold(hold_base),
        .out_clk_o(), .out_clk_oe_n(), .lock_pin_i(lock_pin_i), .lock_pin_o(),
        .lock_pin_oe_n());
    plc_board_clk u_plc_board_clk (.clk(clk), .run1(run1), .run2(run2), .half(half),
        .out_clk(out_clk_o), .pin1(pin1), .pin2(pin2), .fb(ext_fb));

    task automatic report_and_stop;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask

    // bounded wait; running out counts a mismatch and ends the run
    task automatic wait_hold(input logic [3:0] exp, input int bound);
        int n;
        n = 0;
        while (tree_hold !== exp && n < bound) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({28'h0, tree_hold}, {28'h0, exp});
        if (tree_hold !== exp) begin
            report_and_stop();
        end
    endtask

    function automatic logic [31:0] near(input int got, input int exp);
        return {31'h0, got >= exp - 3 && got <= exp + 3};
    endfunction

    task automatic t_reset;
        chk({28'h0, tree_hold}, 32'h0000_000f);
        chk({28'h0, out_clk_oe_n & lock_pin_oe_n}, 32'h0000_000f);
        chk({28'h0, tree_en}, 32'h0000_0000);
        rd_chk(plc_pkg::ADDR_CTRL, 32'h0000_0000);
        rd_chk(plc_pkg::ADDR_ERR, 32'h0000_0000);
        rd_chk(8'h30, plc_pkg::CFG0_RST);
        rd_chk(8'h24, plc_pkg::CFG1_RST);
        rd_chk(8'h50, 32'h0000_0000);
    endtask

    task automatic t_pairs;
        logic [31:0] last;
        last = 32'h0000_0000;
        for (int f2 = 0; f2 < 3; f2++) begin
            for (int f1 = 0; f1 < 3; f1++) begin
                wr_reg(plc_pkg::ADDR_CTRL, 32'(f2 * 4 + f1));
                if (f1 <= f2) begin
                    last = 32'(f2 * 4 + f1);
                end
                rd_chk(plc_pkg::ADDR_CTRL, last);
                rd_chk(plc_pkg::ADDR_ERR, {31'h0, f1 > f2});
                wr_reg(plc_pkg::ADDR_ERR, 32'h0000_000f);
            end
        end
    endtask

    task automatic t_range;
        logic [31:0] tv [6];
        logic [31:0] keep;
        tv = '{32'h1010_a0a0, 32'h1010_a0a1, 32'h1000_a0a0, 32'h1110_a0a0, 32'h1010_01a0,
               32'h0101_0202};
        keep = plc_pkg::CFG0_RST;
        for (int i = 0; i < 6; i++) begin
            wr_reg(plc_pkg::ADDR_PLL, tv[i]);
            if (i == 0 || i == 5) begin
                keep = tv[i];
            end
            rd_chk(plc_pkg::ADDR_PLL, keep);
            rd_chk(plc_pkg::ADDR_ERR, (i == 0 || i == 5) ? 32'h0000_0000 : 32'h0000_0002);
            wr_reg(plc_pkg::ADDR_ERR, 32'h0000_000f);
        end
    endtask

    // pll0 serial, pin out and lock pin; pll1 on pin 2 as user pin; 2,3 rate mixes, 3 fed back
    task automatic t_setup;
        wr_reg(8'h14, 32'h001c_0000);
        wr_reg(8'h20, 32'h0101_0204);
        wr_reg(8'h24, 32'h00e0_0000);
        wr_reg(8'h30, 32'h0102_0202);
        wr_reg(8'h34, 32'h0000_3fff);
        wr_reg(8'h40, 32'h0101_0402);
        wr_reg(8'h44, 32'h0007_0000);
        rd_chk(8'h34, 32'h0000_3fff);
        rd_chk(8'h14, 32'h001c_0000);
        chk({31'h0, out_clk_oe_n[0]}, 32'h0000_0000);
    endtask

    task automatic t_cfg_gate;
        logic [31:0] d;
        repeat (200) @(posedge clk);
        #1;
        chk({28'h0, tree_hold}, 32'h0000_000f);
        chk({31'h0, hold_base[0]}, 32'h0000_0000);
        rd_reg(8'h18, d);
        chk(d & 32'h0000_0001, 32'h0000_0000);
        @(posedge clk);
        cfg_done <= 1'b1;
        wait_hold(4'h0, plc_pkg::LOCK_CYCLES);
        rd_reg(8'h18, d);
        chk({d[31:16], 15'h0, d[0]}, 32'h0010_0001);
        rd_reg(8'h38, d);
        chk(d & 32'h0000_0002, 32'h0000_0002);
        chk({28'h0, lock_pin_o & 4'h3}, 32'h0000_0003);
        chk({28'h0, lock_pin_oe_n & 4'h3}, 32'h0000_0000);
    endtask

    task automatic t_rates;
        logic prev;
        pcnt = '{0, 0, 0, 0};
        togs = 0;
        prev = out_clk_o[0];
        repeat (320) begin
            @(posedge clk);
            #1;
            for (int i = 0; i < 4; i++) begin
                pcnt[i] += int'(tree_en[i]);
            end
            togs += int'(out_clk_o[0] != prev);
            prev = out_clk_o[0];
        end
        chk(near(pcnt[0], 160), 32'h0000_0001);
        chk(near(pcnt[1], 40), 32'h0000_0001);
        chk(near(pcnt[2], 10), 32'h0000_0001);
        chk(near(pcnt[3], 40), 32'h0000_0001);
        chk(near(togs, 160), 32'h0000_0001);
    endtask

    // pin 1 stops: plls on it drop, pll1 on pin 2 keeps running
    task automatic t_loss;
        @(posedge clk);
        run1 <= 1'b0;
        wait_hold(4'hd, 100);
        chk({31'h0, lock_pin_o[0]}, 32'h0000_0000);
        @(posedge clk);
        run1 <= 1'b1;
        wait_hold(4'h0, plc_pkg::LOCK_CYCLES);
    endtask

    // base part: pin 2 shared while pin 1 still toggles is flagged, lock kept
    task automatic t_share;
        logic [31:0] d;
        wr_reg(plc_pkg::ADDR_CTRL, 32'h0000_001a);
        repeat (40) @(posedge clk);
        rd_reg(plc_pkg::ADDR_ERR, d);
        chk(d, 32'h0000_0000);
        chk(rdata_base, 32'h0000_0004);
        chk({31'h0, hold_base[0]}, 32'h0000_0000);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_pairs();
        t_range();
        t_setup();
        t_cfg_gate();
        t_rates();
        t_loss();
        t_share();
        report_and_stop();
    end
endmodule
`default_nettype wire
